// ---- logic/lin_frame_status_flags.sv ----
// Purpose: frame level status flags of a single-wire bus interface
// Assumes: engine strobes are one-cycle pulses on aclk
// Notes:   flags are write-one-to-clear; irq status clears on read
`default_nettype none
module lin_frame_status_flags
   import lin_flags_pkg::*;
(
   // clock and reset
   input  wire  logic        aclk,
   input  wire  logic        aresetn,
   // write address channel
   input  wire  logic [31:0] awaddr,
   input  wire  logic        awvalid,
   output var   logic        awready,
   // write data channel
   input  wire  logic [31:0] wdata,
   input  wire  logic [3:0]  wstrb,
   input  wire  logic        wvalid,
   output var   logic        wready,
   // write response channel
   output var   logic [1:0]  bresp,
   output var   logic        bvalid,
   input  wire  logic        bready,
   // read address channel
   input  wire  logic [31:0] araddr,
   input  wire  logic        arvalid,
   output var   logic        arready,
   // read data channel
   output var   logic [31:0] rdata,
   output var   logic [1:0]  rresp,
   output var   logic        rvalid,
   input  wire  logic        rready,
   // protocol engine events
   input  wire  logic        break_detect,
   input  wire  logic        collision_abort,
   input  wire  logic        collision_in_data,
   input  wire  logic        frame_end,
   input  wire  logic        checksum_mismatch,
   input  wire  logic        node_address_match,
   input  wire  logic        id_received,
   input  wire  logic        id_parity_ok,
   input  wire  logic [5:0]  id_value,
   input  wire  logic        tx_checksum_sent,
   input  wire  logic [7:0]  byte_count_register,
   // interface control and interrupts
   output var   logic        interface_enable,
   output var   logic        event_irq_line,
   output var   logic        error_irq_line,
   output var   logic        irq
);

   function automatic logic [31:0] strobe_mask(input logic [3:0] strobes);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{strobes[i]}};
      end
      return m;
   endfunction : strobe_mask

   function automatic logic [31:0] widen16(input logic [15:0] v);
      return {16'h0000, v};
   endfunction : widen16

   logic [31:0]            aw_addr;
   logic                   aw_held;
   logic [31:0]            w_data;
   logic [3:0]             w_strb;
   logic                   w_held;
   logic                   do_write;
   logic [31:0]            wmask;
   logic                   do_read;
   logic [15:0]            interface_control;
   logic [FLAG_COUNT-1:0]  bus_status_flags;
   logic                   incomplete_frame_flag;
   logic                   first_frame;
   logic [EVENT_COUNT-1:0] irq_mask;
   logic [EVENT_COUNT-1:0] irq_status;
   logic [FLAG_COUNT-1:0]  flag_set;
   logic [FLAG_COUNT-1:0]  flag_w1c;
   logic                   incomplete_set;
   logic                   is_diag_id;
   logic [4:0]             expected_count;
   logic [4:0]             actual_count;
   logic [31:0]            smask;
   logic                   wr_control;
   logic                   wr_flags;
   logic                   wr_incomplete;
   logic                   wr_mask;
   logic                   rd_status;

   // write path
   // a response not yet taken holds off the next write
   assign do_write = aw_held && w_held && !bvalid;
   assign smask    = strobe_mask(w_strb);
   assign wmask    = smask & w_data;
   assign do_read  = arvalid && arready;

   // register write and read strobes
   assign wr_control    = do_write && aw_addr == CONTROL_ADDR;
   assign wr_flags      = do_write && aw_addr == FLAGS_ADDR;
   assign wr_incomplete = do_write && aw_addr == INCOMPLETE_ADDR;
   assign wr_mask       = do_write && aw_addr == IRQ_MASK_ADDR && w_strb[0];
   assign rd_status     = do_read && araddr == IRQ_STATUS_ADDR;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_held <= 1'b1;
         aw_addr <= awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end else if (!aw_held && !bvalid && !awready) begin
         awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready <= 1'b0;
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_held <= 1'b1;
         w_data <= wdata;
         w_strb <= wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end else if (!w_held && !bvalid && !wready) begin
         wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         case (aw_addr)
            CONTROL_ADDR, FLAGS_ADDR, INCOMPLETE_ADDR,
            IRQ_MASK_ADDR, IRQ_STATUS_ADDR: bresp <= RESP_OKAY;
            default:                        bresp <= RESP_SLVERR;
         endcase
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // read path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else if (do_read) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= RESP_OKAY;
         case (araddr)
            CONTROL_ADDR:    rdata <= widen16(interface_control);
            FLAGS_ADDR:      rdata <= {26'h0, bus_status_flags};
            INCOMPLETE_ADDR: rdata <= {31'h0, incomplete_frame_flag};
            IRQ_MASK_ADDR:   rdata <= {25'h0, irq_mask};
            IRQ_STATUS_ADDR: rdata <= {25'h0, irq_status};
            default: begin
               rdata <= '0;
               rresp <= RESP_SLVERR;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end else if (!rvalid && !arready) begin
         arready <= 1'b1;
      end
   end

   // control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         interface_control <= CONTROL_RESET;
      end else if (wr_control) begin
         // only writable bits under enabled byte lanes change
         interface_control <= (interface_control & ~(smask[15:0] & CONTROL_WRITABLE))
                            | (wmask[15:0] & CONTROL_WRITABLE);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         interface_enable <= 1'b0;
      end else begin
         interface_enable <= interface_control[ENABLE_BIT];
      end
   end

   // event decode from the protocol engine
   assign is_diag_id     = id_value == DIAG_ID;
   assign expected_count = {1'b0, byte_count_register[3:0]} + 5'h01;
   assign actual_count   = {1'b0, byte_count_register[7:4]};

   always_comb begin
      flag_set                = '0;
      flag_set[COLLISION_BIT] = collision_abort && collision_in_data;
      flag_set[CHECKSUM_BIT]  = frame_end && checksum_mismatch;
      flag_set[PARITY_BIT]    = id_received && !id_parity_ok;
      flag_set[TX_DONE_BIT]   = tx_checksum_sent;
      flag_set[FRAME_BIT]     = frame_end && !checksum_mismatch
                              && (!is_diag_id || node_address_match);
      flag_set[HEADER_BIT]    = id_received && id_parity_ok
                              && (!is_diag_id || interface_control[DIAG_HEADER_BIT]);
      flag_set                = flag_set & {FLAG_COUNT{interface_control[ENABLE_BIT]}};
   end

   // first break after enable, or a count mismatch with an expected count above one
   assign incomplete_set = break_detect && interface_control[ENABLE_BIT]
                         && (first_frame
                         || (byte_count_register[3:0] != 4'h0
                         && expected_count != actual_count));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_frame <= 1'b0;
      end else if (!interface_control[ENABLE_BIT]) begin
         first_frame <= 1'b1;
      end else if (break_detect) begin
         first_frame <= 1'b0;
      end
   end

   // write-one-to-clear of the flags; zeros leave them alone
   assign flag_w1c = wr_flags ? wmask[FLAG_COUNT-1:0] : '0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus_status_flags <= '0;
      end else begin
         for (int i = 0; i < FLAG_COUNT; i++) begin
            // a set outranks any clear in the same cycle
            if (flag_set[i]) begin
               bus_status_flags[i] <= 1'b1;
            end else if (break_detect || flag_w1c[i]) begin
               bus_status_flags[i] <= 1'b0;
            end else if (i == COLLISION_BIT && !interface_control[ENABLE_BIT]) begin
               bus_status_flags[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         incomplete_frame_flag <= 1'b0;
      end else if (incomplete_set) begin
         incomplete_frame_flag <= 1'b1;
      end else if (wr_incomplete && wmask[0]) begin
         incomplete_frame_flag <= 1'b0;
      end
   end

   // interrupt mask and read-clear sticky status
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask <= '0;
      end else if (wr_mask) begin
         irq_mask <= w_data[EVENT_COUNT-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= '0;
      end else if (rd_status) begin
         // an event in the read cycle survives the clear
         irq_status <= {incomplete_set, flag_set};
      end else begin
         irq_status <= irq_status | {incomplete_set, flag_set};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         event_irq_line <= 1'b0;
         error_irq_line <= 1'b0;
         irq            <= 1'b0;
      end else begin
         event_irq_line <= |(bus_status_flags & irq_mask[FLAG_COUNT-1:0] & EVENT_GROUP);
         error_irq_line <= |(bus_status_flags & irq_mask[FLAG_COUNT-1:0] & ERROR_GROUP);
         irq            <= |(irq_status & irq_mask);
      end
   end

endmodule : lin_frame_status_flags
`default_nettype wire

// ---- pkg/lin_flags_pkg.sv ----
// Purpose: constants for the frame status flag block
// Assumes: aclk at 20 MHz, AXI4-Lite with 32-bit data
// Notes:   register offsets are byte addresses
`default_nettype none
package lin_flags_pkg;
   localparam logic [31:0] CONTROL_ADDR      = 32'h4000_5000;
   localparam logic [31:0] FLAGS_ADDR        = 32'h4000_5034;
   localparam logic [31:0] INCOMPLETE_ADDR   = 32'h4000_5038;
   localparam logic [31:0] IRQ_MASK_ADDR     = 32'h4000_5068;
   localparam logic [31:0] IRQ_STATUS_ADDR   = 32'h4000_506c;
   localparam int          HEADER_BIT        = 0;
   localparam int          FRAME_BIT         = 1;
   localparam int          TX_DONE_BIT       = 2;
   localparam int          PARITY_BIT        = 3;
   localparam int          CHECKSUM_BIT      = 4;
   localparam int          COLLISION_BIT     = 5;
   localparam int          INCOMPLETE_BIT    = 6;
   localparam int          ENABLE_BIT        = 0;
   localparam int          DIAG_HEADER_BIT   = 14;
   localparam int          FLAG_COUNT        = 6;
   localparam int          EVENT_COUNT       = 7;
   localparam logic [5:0]  DIAG_ID           = 6'h3c;
   localparam logic [5:0]  EVENT_GROUP       = 6'h07;
   localparam logic [5:0]  ERROR_GROUP       = 6'h38;
   localparam logic [15:0] CONTROL_RESET     = 16'h0000;
   localparam logic [15:0] CONTROL_WRITABLE  = 16'h4001;
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;
endpackage : lin_flags_pkg
`default_nettype wire

// ---- tb/lin_bus_nodes.sv ----
// Purpose: far-side node model raising engine events
// Assumes: go lasts one cycle with kind steady
// Notes:   each event is a one-cycle pulse after go
`default_nettype none
module lin_bus_nodes (
   // request from the bench
   input  wire logic       aclk,
   input  wire logic       go,
   input  wire logic [2:0] kind,
   // engine events
   output var  logic       break_detect,
   output var  logic       collision_abort,
   output var  logic       frame_end,
   output var  logic       id_received,
   output var  logic       tx_checksum_sent
);
   timeunit 1ns;
   timeprecision 1ns;
   always @(posedge aclk) begin
      break_detect     <= go && kind == 3'h0;
      collision_abort  <= go && kind == 3'h1;
      frame_end        <= go && kind == 3'h2;
      id_received      <= go && kind == 3'h3;
      tx_checksum_sent <= go && kind == 3'h4;
   end
endmodule : lin_bus_nodes
`default_nettype wire

// ---- tb/lin_flags_assertions.sv ----
// Purpose: port checks on the frame flag block
// Assumes: one clock, engine pulses last one cycle
// Notes:   masks are internal, so cause checks look back
`default_nettype none
module lin_flags_assertions
   import lin_flags_pkg::*;
(
   // clock, reset and bus
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] araddr,
   input wire logic [1:0]  rresp,
   // engine events and outputs
   input wire logic        break_detect,
   input wire logic        collision_abort,
   input wire logic        collision_in_data,
   input wire logic        frame_end,
   input wire logic        checksum_mismatch,
   input wire logic        id_received,
   input wire logic        id_parity_ok,
   input wire logic        tx_checksum_sent,
   input wire logic        interface_enable,
   input wire logic        event_irq_line,
   input wire logic        error_irq_line
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic err_ev, evt_ev, quiet, mapped;
   assign err_ev = collision_abort && collision_in_data || frame_end && checksum_mismatch || id_received && !id_parity_ok;
   assign evt_ev = frame_end || id_received && id_parity_ok || tx_checksum_sent;
   assign quiet  = !collision_abort && !frame_end && !id_received && !tx_checksum_sent;
   assign mapped = araddr inside {CONTROL_ADDR, FLAGS_ADDR, INCOMPLETE_ADDR, IRQ_MASK_ADDR, IRQ_STATUS_ADDR};
   sequence quiet_break_s; break_detect && quiet ##1 quiet; endsequence
   sequence wr_taken_s; awvalid && awready && wvalid && wready; endsequence
   bvalid_hold_a: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped early");
   rvalid_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rresp)) else $error("read answer moved");
   read_answer_a: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
   write_answer_a: assert property (wr_taken_s |=> ##1 bvalid) else $error("write answer late");
   write_busy_a: assert property (bvalid |-> !awready && !wready) else $error("write taken while busy");
   break_clear_a: assert property (quiet_break_s |=> !error_irq_line && !event_irq_line)
      else $error("lines stay after break");
   err_cause_a: assert property ($rose(error_irq_line) |-> $past(err_ev, 2) || $past(bvalid))
      else $error("error line without cause");
   evt_cause_a: assert property ($rose(event_irq_line) |-> $past(evt_ev, 2) || $past(bvalid))
      else $error("event line without cause");
   enable_src_a: assert property ($changed(interface_enable) |-> $past(bvalid))
      else $error("enable moved without write");
   unmapped_rd_a: assert property (arvalid && arready && !mapped |=> rresp == RESP_SLVERR) else $error("no slverr");
endmodule : lin_flags_assertions
bind lin_frame_status_flags lin_flags_assertions chk (.*);
`default_nettype wire

// ---- tb/lin_frame_status_flags_tb_top.sv ----
// Purpose: self-checking bench for the frame status flags
// Assumes: bus answers come within a few cycles
// Notes:   row table covers each flag source at least once
`default_nettype none
module lin_frame_status_flags_tb_top
   import lin_flags_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [2:0] kind; logic [1:0] q; logic [5:0] id; logic [5:0] exp;} row_t;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] awaddr, wdata, araddr, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic        break_detect, collision_abort, collision_in_data, frame_end, checksum_mismatch, node_address_match;
   logic        id_received, id_parity_ok, tx_checksum_sent, interface_enable, event_irq_line, error_irq_line, irq, go;
   logic [5:0]  id_value;
   logic [7:0]  byte_count_register;
   logic [2:0]  kind;
   int          fails, n_checks;
   row_t rows[10] = '{'{3'h1, 2'h1, 6'h00, 6'h20}, '{3'h1, 2'h0, 6'h00, 6'h00}, '{3'h2, 2'h1, 6'h05, 6'h10},
      '{3'h2, 2'h0, 6'h05, 6'h02}, '{3'h2, 2'h0, 6'h3c, 6'h00}, '{3'h2, 2'h2, 6'h3c, 6'h02},
      '{3'h3, 2'h0, 6'h05, 6'h08}, '{3'h3, 2'h1, 6'h05, 6'h01}, '{3'h3, 2'h1, 6'h3c, 6'h00}, '{3'h4, 2'h0, 6'h00, 6'h04}};
   // byte count, then whether the incomplete flag should set
   logic [8:0]  counts[3] = '{9'h064, 9'h045, 9'h040};
   lin_frame_status_flags DUT (.*);
   lin_bus_nodes nodes (.*);
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         r = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (!tb);
   endtask : wr
   task automatic rd(input logic [31:0] a);
      logic ta, tr;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(negedge aclk);
         ta = arvalid && arready;
         tr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
      end while (!tr);
   endtask : rd
   task automatic ev(input logic [2:0] k);
      kind <= k;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask : ev
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      end_of_test();
   end
   initial begin
      {aresetn, awvalid, wvalid, arvalid, go, kind, awaddr, wdata, araddr} = '0;
      {bready, rready} = 2'h3;
      {collision_in_data, checksum_mismatch, node_address_match, id_parity_ok, id_value, byte_count_register} = '0;
      wstrb = 4'hf;
      fails = 0;
      n_checks = 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(CONTROL_ADDR);
      chk("control", d, 32'h0);
      rd(INCOMPLETE_ADDR);
      chk("incomplete", d, 32'h0);
      $display("reset done");
      wr(IRQ_MASK_ADDR, 32'h7f);
      chk("bresp", r, RESP_OKAY);
      wr(CONTROL_ADDR, 32'h1);
      @(posedge aclk);
      chk("enable", interface_enable, 1'b1);
      ev(3'h0);
      rd(INCOMPLETE_ADDR);
      chk("first", d, 32'h1);
      wr(INCOMPLETE_ADDR, 32'h0);
      rd(INCOMPLETE_ADDR);
      chk("w0", d, 32'h1);
      // software leans on the count register; the flag is a cross-check only
      wr(INCOMPLETE_ADDR, 32'h1);
      rd(INCOMPLETE_ADDR);
      chk("w1", d, 32'h0);
      foreach (counts[i]) begin
         byte_count_register <= counts[i][8:1];
         ev(3'h0);
         rd(INCOMPLETE_ADDR);
         chk("count", d, {31'h0, counts[i][0]});
         wr(INCOMPLETE_ADDR, 32'h1);
      end
      $display("incomplete done");
      foreach (rows[i]) begin
         {node_address_match, collision_in_data} <= rows[i].q;
         checksum_mismatch <= rows[i].q[0];
         id_parity_ok <= rows[i].q[0];
         id_value <= rows[i].id;
         ev(rows[i].kind);
         rd(FLAGS_ADDR);
         chk("flags", d, {26'h0, rows[i].exp});
         chk("err_line", error_irq_line, |(rows[i].exp & ERROR_GROUP));
         chk("evt_line", event_irq_line, |(rows[i].exp & EVENT_GROUP));
         wr(FLAGS_ADDR, 32'h3f);
         rd(FLAGS_ADDR);
         chk("w1c", d, 32'h0);
         $display("row %0d done", i);
      end
      collision_in_data <= 1'b1;
      ev(3'h1);
      ev(3'h4);
      ev(3'h0);
      rd(FLAGS_ADDR);
      chk("break", d, 32'h0);
      ev(3'h1);
      ev(3'h4);
      wr(CONTROL_ADDR, 32'h0);
      rd(FLAGS_ADDR);
      chk("disable", d, 32'h4);
      wr(FLAGS_ADDR, 32'h3f);
      wr(CONTROL_ADDR, 32'h4001);
      id_parity_ok <= 1'b1;
      id_value <= DIAG_ID;
      ev(3'h3);
      rd(FLAGS_ADDR);
      chk("diag_hdr", d, 32'h1);
      wr(FLAGS_ADDR, 32'h3f);
      rd(IRQ_STATUS_ADDR);
      wr(IRQ_MASK_ADDR, 32'h0);
      ev(3'h1);
      chk("masked", error_irq_line, 1'b0);
      chk("irq", irq, 1'b0);
      rd(IRQ_STATUS_ADDR);
      chk("status", d, 32'h20);
      rd(IRQ_STATUS_ADDR);
      chk("status_clr", d, 32'h0);
      wr(IRQ_MASK_ADDR, 32'h7f);
      repeat (2) @(posedge aclk);
      chk("unmasked", error_irq_line, 1'b1);
      wr(FLAGS_ADDR, 32'h3f);
      repeat (2) @(posedge aclk);
      chk("cleared", error_irq_line, 1'b0);
      ev(3'h4);
      chk("irq_on", irq, 1'b1);
      rd(IRQ_STATUS_ADDR);
      chk("irq_stat", d, 32'h4);
      repeat (2) @(posedge aclk);
      chk("irq_off", irq, 1'b0);
      $display("clear and irq done");
      wstrb <= 4'h2;
      wr(CONTROL_ADDR, 32'h0);
      wstrb <= 4'hf;
      rd(CONTROL_ADDR);
      chk("lanes", d, 32'h1);
      wr(32'h4000_5004, 32'h1);
      chk("wr_slverr", r, RESP_SLVERR);
      rd(32'h4000_5004);
      chk("slverr", r, RESP_SLVERR);
      chk("rdata", d, 32'h0);
      $display("unmapped done");
      end_of_test();
   end
endmodule : lin_frame_status_flags_tb_top
`default_nettype wire
